// file: rtl/pri_controller.v
// eight-input priority interrupt controller with AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pri_consts.vh"
module pri_controller #(
  parameter NUM = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM-1:0] request_inputs,
  input wire acknowledge_pulse_n,
  output wire int_request,
  output reg [7:0] vector_out,
  output reg vector_oe,
  input wire [2:0] cascade_in,
  output reg [2:0] cascade_out,
  output reg cascade_oe
);

  localparam ST_IDLE = 3'b001;
  localparam ST_FIRST = 3'b010;
  localparam ST_SECOND = 3'b100;

  // first set bit scanning upward from start, wrapping
  function [3:0] first_from;
    input [7:0] v;
    input [2:0] start;
    integer i;
    reg [2:0] k;
    reg found;
    begin
      first_from = 4'h0;
      found = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        k = start + i[2:0];
        if (v[k] && !found)
        begin
          found = 1'b1;
          first_from = {1'b1, k};
        end
      end
    end
  endfunction

  reg [7:0] init_word_first;
  reg [7:0] init_word_vector;
  reg [7:0] init_word_cascade;
  reg [7:0] init_word_fourth;
  reg [7:0] mask_register;
  reg [7:0] request_register;
  reg [7:0] in_service_register;
  reg [2:0] bottom;
  reg rotate_auto;
  reg special_mask;
  reg poll_armed;
  reg [2:0] state;
  reg [2:0] ack_level;
  reg responder;
  reg [7:0] req_s1;
  reg [7:0] req_s2;
  reg [7:0] req_s3;
  reg ack_s1;
  reg ack_s2;
  reg ack_s3;
  reg [2:0] cas_s1;
  reg [2:0] cas_s2;
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire single = init_word_first[`PRI_FIRST_SINGLE];
  wire edge_mode = init_word_first[`PRI_FIRST_EDGE];
  wire auto_end = init_word_fourth[`PRI_FOURTH_AUTO];
  wire special_nested = init_word_fourth[`PRI_FOURTH_NESTED];
  wire is_slave = !single && !init_word_fourth[`PRI_FOURTH_MASTER];
  wire [2:0] highest = bottom + 3'h1;
  wire ack_fall = ack_s3 && !ack_s2;
  wire ack_rise = !ack_s3 && ack_s2;

  // priority resolution
  // [RULE_12] masked inputs excluded
  wire [7:0] candidate = request_register & ~mask_register;
  wire [7:0] cand_open = candidate & ~in_service_register;
  // [RULE_09] scan starts one above bottom
  wire [3:0] top_service = first_from(in_service_register, highest);
  wire [3:0] top_request = first_from(candidate, highest);
  wire [3:0] top_open = first_from(cand_open, highest);
  wire [2:0] rank_service = top_service[2:0] - highest;
  wire [2:0] rank_request = top_request[2:0] - highest;
  wire top_is_cascade = !single && !is_slave &&
    init_word_cascade[top_service[2:0]];
  reg [3:0] winner;

  // blocking by the highest level in service
  always @*
  begin
    winner = 4'h0;
    // [RULE_14] special mask skips only in-service levels
    if (special_mask)
      winner = top_open;
    // [RULE_02] only higher levels pass while one is served
    else if (!top_service[3])
      winner = top_request;
    // [RULE_04] same cascaded level may re-request
    else if (special_nested && top_is_cascade &&
             rank_request == rank_service)
      winner = top_request;
    // [RULE_13] masked in-service level still blocks lower
    else if (top_request[3] && rank_request < rank_service)
      winner = top_request;
  end

  // [RULE_19] single request line to the processor
  assign int_request = winner[3];

  // synchronisers for pins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_s1 <= 8'h00;
      req_s2 <= 8'h00;
      req_s3 <= 8'h00;
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      ack_s3 <= 1'b1;
      cas_s1 <= 3'h0;
      cas_s2 <= 3'h0;
    end
    else
    begin
      req_s1 <= request_inputs;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      ack_s1 <= acknowledge_pulse_n;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      cas_s1 <= cascade_in;
      cas_s2 <= cas_s1;
    end
  end

  // bus handshake
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && !s_axi_rvalid;
  wire wr_low = do_write && w_strb[0];
  wire rd_poll = do_read && s_axi_araddr == `PRI_OFS_POLL;
  wire [2:0] cmd_kind = w_data[7:5];
  wire [2:0] cmd_level = w_data[2:0];
  wire wr_cmd = wr_low && aw_addr == `PRI_OFS_COMMAND;
  wire wr_first = wr_low && aw_addr == `PRI_OFS_FIRST;
  wire aw_hit = aw_addr == `PRI_OFS_FIRST ||
    aw_addr == `PRI_OFS_VECTOR || aw_addr == `PRI_OFS_CASCADE ||
    aw_addr == `PRI_OFS_FOURTH || aw_addr == `PRI_OFS_MASK ||
    aw_addr == `PRI_OFS_COMMAND || aw_addr == `PRI_OFS_MODE;

  // write address and data captured in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRI_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_hit ? `PRI_RESP_OKAY : `PRI_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read data path
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PRI_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PRI_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == `PRI_OFS_FIRST)
        s_axi_rdata[7:0] <= init_word_first;
      else if (s_axi_araddr == `PRI_OFS_VECTOR)
        s_axi_rdata[7:0] <= init_word_vector;
      else if (s_axi_araddr == `PRI_OFS_CASCADE)
        s_axi_rdata[7:0] <= init_word_cascade;
      else if (s_axi_araddr == `PRI_OFS_FOURTH)
        s_axi_rdata[7:0] <= init_word_fourth;
      // [RULE_18] registers read back
      else if (s_axi_araddr == `PRI_OFS_MASK)
        s_axi_rdata[7:0] <= mask_register;
      else if (s_axi_araddr == `PRI_OFS_MODE)
        s_axi_rdata[1:0] <= {poll_armed, special_mask};
      else if (s_axi_araddr == `PRI_OFS_REQUEST)
        s_axi_rdata[7:0] <= request_register;
      else if (s_axi_araddr == `PRI_OFS_SERVICE)
        s_axi_rdata[7:0] <= in_service_register;
      else if (s_axi_araddr == `PRI_OFS_PRIORITY)
        s_axi_rdata[3:0] <= {rotate_auto, bottom};
      // [RULE_25] pending flag and level
      else if (s_axi_araddr == `PRI_OFS_POLL)
        s_axi_rdata[7:0] <= poll_armed ?
          {winner[3], 4'h0, winner[2:0]} : 8'h00;
      else
        s_axi_rresp <= `PRI_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // configuration and mode registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      init_word_first <= `PRI_RST_FIRST;
      init_word_vector <= `PRI_RST_BYTE;
      init_word_cascade <= `PRI_RST_BYTE;
      init_word_fourth <= `PRI_RST_BYTE;
      mask_register <= `PRI_RST_BYTE;
      special_mask <= 1'b0;
      poll_armed <= 1'b0;
      rotate_auto <= 1'b0;
      bottom <= `PRI_RST_BOTTOM;
    end
    else
    begin
      // [RULE_21] first word accepted only with bits 0 and 4
      if (wr_first && w_data[`PRI_FIRST_ID0] && w_data[`PRI_FIRST_ID4])
      begin
        init_word_first <= w_data[7:0];
        mask_register <= `PRI_RST_BYTE;
        special_mask <= 1'b0;
        bottom <= `PRI_RST_BOTTOM;
      end
      // [RULE_22] low three vector bits kept zero
      if (wr_low && aw_addr == `PRI_OFS_VECTOR)
        init_word_vector <= {w_data[7:3], 3'h0};
      // [RULE_20] any input may carry a slave
      if (wr_low && aw_addr == `PRI_OFS_CASCADE)
        init_word_cascade <= w_data[7:0];
      if (wr_low && aw_addr == `PRI_OFS_FOURTH)
        init_word_fourth <= w_data[7:0];
      // [RULE_12] mask writable at any time
      if (wr_low && aw_addr == `PRI_OFS_MASK)
        mask_register <= w_data[7:0];
      if (wr_low && aw_addr == `PRI_OFS_MODE)
      begin
        special_mask <= w_data[`PRI_MODE_SMASK];
        poll_armed <= w_data[`PRI_MODE_POLL];
      end
      // [RULE_15] poll consumed by the next poll read
      if (rd_poll)
        poll_armed <= 1'b0;
      if (wr_cmd)
      begin
        // [RULE_08] rotating end makes served level lowest
        if (cmd_kind == `PRI_CMD_ROT_END && top_service[3])
          bottom <= top_service[2:0];
        // [RULE_10] specific rotate end sets bottom
        if (cmd_kind == `PRI_CMD_ROT_SPEC)
          bottom <= cmd_level;
        // [RULE_11] bottom set without ending service
        if (cmd_kind == `PRI_CMD_SET_BOTTOM)
          bottom <= cmd_level;
        if (cmd_kind == `PRI_CMD_ROT_AUTO_ON)
          rotate_auto <= 1'b1;
        if (cmd_kind == `PRI_CMD_ROT_AUTO_OFF)
          rotate_auto <= 1'b0;
      end
      // [RULE_08] rotation at automatic end
      if (state == ST_SECOND && ack_rise && auto_end && rotate_auto)
        bottom <= ack_level;
    end
  end

  // request latches; a new edge wins over the acknowledge clear
  genvar g;
  generate
    for (g = 0; g < NUM; g = g + 1)
    begin : g_req
      wire taken = (state == ST_IDLE && ack_fall && !is_slave ||
                    state == ST_FIRST && ack_fall && is_slave ||
                    rd_poll && poll_armed) &&
                   winner[3] && winner[2:0] == g;
      always @(posedge aclk)
      begin
        if (!aresetn)
          request_register[g] <= 1'b0;
        // [RULE_16] level mode follows the input
        else if (!edge_mode)
          request_register[g] <= req_s2[g];
        // [RULE_21] edge mode latches rising transitions
        else if (req_s2[g] && !req_s3[g])
          request_register[g] <= 1'b1;
        else if (taken || !req_s2[g])
          request_register[g] <= 1'b0;
      end
    end
  endgenerate

  // in-service register and acknowledge sequence
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_service_register <= 8'h00;
      state <= ST_IDLE;
      ack_level <= 3'h0;
      responder <= 1'b0;
      vector_out <= 8'h00;
      vector_oe <= 1'b0;
      cascade_out <= 3'h0;
      cascade_oe <= 1'b0;
    end
    else
    begin
      // clears first, so a same-cycle set wins
      if (wr_cmd)
      begin
        // [RULE_03] plain end clears highest served level
        if ((cmd_kind == `PRI_CMD_END ||
             cmd_kind == `PRI_CMD_ROT_END) && top_service[3])
          in_service_register[top_service[2:0]] <= 1'b0;
        // [RULE_10] specific end clears the named level
        if (cmd_kind == `PRI_CMD_SPEC_END ||
            cmd_kind == `PRI_CMD_ROT_SPEC)
          in_service_register[cmd_level] <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          if (ack_fall)
          begin
            state <= ST_FIRST;
            ack_level <= winner[2:0];
            // [RULE_01] frozen winner is highest ranked
            responder <= winner[3];
            // [RULE_17] set at first pulse on the master
            if (!is_slave && winner[3])
              in_service_register[winner[2:0]] <= 1'b1;
            // [RULE_26] cascade code for a slave level
            if (!single && !is_slave && winner[3] &&
                init_word_cascade[winner[2:0]])
            begin
              cascade_out <= winner[2:0];
              cascade_oe <= 1'b1;
              responder <= 1'b0;
            end
          end
        end
        ST_FIRST:
        begin
          if (ack_fall)
          begin
            state <= ST_SECOND;
            // [RULE_24] slave answers only on identifier match
            if (is_slave)
            begin
              ack_level <= winner[2:0];
              responder <= winner[3] &&
                cas_s2 == init_word_cascade[2:0];
              if (winner[3] && cas_s2 == init_word_cascade[2:0])
              begin
                in_service_register[winner[2:0]] <= 1'b1;
                vector_out <= {init_word_vector[7:3], winner[2:0]};
                vector_oe <= 1'b1;
              end
            end
            // [RULE_07] cascaded levels left to the slave
            else if (responder)
            begin
              // [RULE_22] vector carries level in low bits
              vector_out <= {init_word_vector[7:3], ack_level};
              vector_oe <= 1'b1;
            end
          end
        end
        ST_SECOND:
        begin
          if (ack_rise)
          begin
            state <= ST_IDLE;
            vector_oe <= 1'b0;
            cascade_oe <= 1'b0;
            // [RULE_23] automatic end at close of acknowledge
            if (auto_end && (responder || !is_slave))
              in_service_register[ack_level] <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
      // [RULE_15] poll read acts as acknowledge; set wins
      if (rd_poll && poll_armed && winner[3])
        in_service_register[winner[2:0]] <= 1'b1;
    end
  end

endmodule // pri_controller

// file: shared/pri_consts.vh
// constants for the priority interrupt controller
//
// Behaviour
// [RULE_01] fixed priority: input zero highest, seven lowest
// [RULE_02] acknowledge delivers winner; lower levels blocked
// [RULE_03] serviced level cleared only by end command
// [RULE_04] special nested: cascaded level not locked out
// [RULE_05] software ends slave first, then master
// [RULE_06] master special nested, slaves plain nested
// [RULE_07] slave supplies vector; master arbitrates slaves
// [RULE_08] automatic rotation: serviced level becomes lowest
// [RULE_09] specific rotation: bottom plus one is highest
// [RULE_10] specific rotate end clears and sets bottom
// [RULE_11] bottom priority settable without ending anything
// [RULE_12] each input individually maskable, masked never interrupts
// [RULE_13] masked in-service level blocks until end command
// [RULE_14] special mask enables all except in-service
// [RULE_15] poll: next read acknowledges and returns level
// [RULE_16] request register, one bit per input
// [RULE_17] in-service register, one bit per input
// [RULE_18] mask register; all three readable
// [RULE_19] one request line; vector names winning level
// [RULE_20] eight inputs, any may carry a slave
// [RULE_21] first word needs bits 0,4; single, edge bits
// [RULE_22] vector: programmed bits 7:3, level bits 2:0
// [RULE_23] automatic end clears in-service at acknowledge
// [RULE_24] slave answers second pulse only on identifier match
// [RULE_25] poll byte: bit 7 pending, bits 2:0 level
// [RULE_26] master drives cascade code during acknowledge
`ifndef PRI_CONSTS_VH
`define PRI_CONSTS_VH
`define PRI_OFS_FIRST 8'h00
`define PRI_OFS_VECTOR 8'h04
`define PRI_OFS_CASCADE 8'h08
`define PRI_OFS_FOURTH 8'h0C
`define PRI_OFS_MASK 8'h10
`define PRI_OFS_COMMAND 8'h14
`define PRI_OFS_MODE 8'h18
`define PRI_OFS_REQUEST 8'h1C
`define PRI_OFS_SERVICE 8'h20
`define PRI_OFS_POLL 8'h24
`define PRI_OFS_PRIORITY 8'h28
`define PRI_FIRST_ID0 0
`define PRI_FIRST_SINGLE 1
`define PRI_FIRST_EDGE 3
`define PRI_FIRST_ID4 4
`define PRI_FOURTH_AUTO 1
`define PRI_FOURTH_MASTER 2
`define PRI_FOURTH_NESTED 4
`define PRI_MODE_SMASK 0
`define PRI_MODE_POLL 1
`define PRI_CMD_END 3'h1
`define PRI_CMD_SPEC_END 3'h3
`define PRI_CMD_ROT_END 3'h5
`define PRI_CMD_ROT_SPEC 3'h7
`define PRI_CMD_SET_BOTTOM 3'h6
`define PRI_CMD_ROT_AUTO_ON 3'h4
`define PRI_CMD_ROT_AUTO_OFF 3'h0
`define PRI_RST_FIRST 8'h13
`define PRI_RST_BYTE 8'h00
`define PRI_RST_BOTTOM 3'h7
`define PRI_RESP_OKAY 2'h0
`define PRI_RESP_SLVERR 2'h2
`endif

// file: tb/pri_host.sv
// host processor model issuing acknowledge pulse pairs
`timescale 1ns/1ps
module pri_host (
  input wire aclk,
  input wire [7:0] vector_out,
  input wire vector_oe,
  input wire [2:0] cascade_out,
  input wire cascade_oe,
  output logic acknowledge_pulse_n
);
  // pin idles high between acknowledge sequences
  initial acknowledge_pulse_n = 1'b1;
  // two six-cycle low pulses; capture whatever the device drives
  task automatic ack(output logic [7:0] v, output logic got,
    output logic [2:0] c);
    int i;
    begin
      got = 1'b0;
      v = 8'h00;
      c = 3'h0;
      for (i = 0; i < 24; i++)
      begin
        @(posedge aclk);
        if (vector_oe === 1'b1)
        begin
          got = 1'b1;
          v = vector_out;
        end
        if (cascade_oe === 1'b1)
          c = cascade_out;
        acknowledge_pulse_n <= (i % 12) >= 6;
      end
    end
  endtask
endmodule // pri_host

// file: tb/pri_props.sv
// concurrent checks on the priority interrupt controller ports
`timescale 1ns/1ps
module pri_props #(
  parameter NUM = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [NUM-1:0] request_inputs,
  input logic acknowledge_pulse_n,
  input logic int_request,
  input logic [7:0] vector_out,
  input logic vector_oe,
  input logic cascade_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // bus handshake and acknowledge steps
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_read_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  sequence s_write_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_req_idle;
    (request_inputs == '0) [*5];
  endsequence
  sequence s_ack_low;
    !acknowledge_pulse_n && $past(acknowledge_pulse_n, 2) == 1'b0;
  endsequence
  a_read_answer: assert property (
    s_read_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_release: assert property (
    s_read_done |=> !s_axi_rvalid)
    else $error("read answer held after taken");
  a_read_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_write_both: assert property (
    $rose(s_axi_bvalid) |-> $past(s_axi_awready) == 1'b0 &&
    $past(s_axi_wready) == 1'b0)
    else $error("write answered before both parts taken");
  a_write_release: assert property (
    s_write_done |=> !s_axi_bvalid)
    else $error("write answer held after taken");
  a_idle_quiet: assert property (
    s_req_idle |-> !int_request)
    else $error("interrupt raised with no request");
  a_vector_late: assert property (
    $rose(vector_oe) |-> s_ack_low)
    else $error("vector driven outside acknowledge pulse");
  a_vector_release: assert property (
    $fell(vector_oe) |-> acknowledge_pulse_n)
    else $error("vector released while pulse low");
  a_vector_steady: assert property (
    vector_oe && $past(vector_oe) |-> $stable(vector_out))
    else $error("vector byte changed while driven");
  a_no_dual_drive: assert property (
    vector_oe |-> !cascade_oe)
    else $error("vector and cascade code driven together");
endmodule // pri_props

bind pri_controller pri_props #(.NUM(NUM)) u_props (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .request_inputs, .acknowledge_pulse_n,
  .int_request, .vector_out, .vector_oe, .cascade_oe
);

// file: tb/tb_top.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
`include "pri_consts.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, acknowledge_pulse_n;
  logic int_request, vector_oe, cascade_oe;
  logic [7:0] s_axi_awaddr, s_axi_araddr, request_inputs, vector_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] cascade_in, cascade_out;
  int n_fail = 0;
  int check_count = 0;
  pri_controller DUT (.*);
  pri_host host (.*);
  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task automatic close_out();
    begin
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // bus write: offer address and data, release each when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er = `PRI_RESP_OKAY);
    logic aw_ok, w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1)
          aw_ok = 1'b1;
        if (s_axi_wready === 1'b1)
          w_ok = 1'b1;
        if (aw_ok)
          s_axi_awvalid <= 1'b0;
        if (w_ok)
          s_axi_wvalid <= 1'b0;
      end
      do
        @(posedge aclk);
      while (s_axi_bvalid !== 1'b1);
      check(s_axi_bresp, er);
    end
  endtask
  // bus read with expected byte and response
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] er = `PRI_RESP_OKAY);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
        @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
        @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, {24'h0, e});
      check(s_axi_rresp, er);
    end
  endtask
  // new request pattern, then let the input synchronisers settle
  task automatic req(input logic [7:0] v);
    begin
      request_inputs <= v;
      repeat (6) @(posedge aclk);
    end
  endtask
  task automatic ci(input logic e);
    begin
      @(posedge aclk);
      check(int_request, e);
    end
  endtask
  task automatic cmd(input logic [2:0] k, input logic [4:0] lvl = 5'h0);
    begin
      wr(`PRI_OFS_COMMAND, {k, lvl});
    end
  endtask
  // full acknowledge; expected vector, driven flag, cascade code
  task automatic ackx(input logic [7:0] ev, input logic eg = 1'b1,
    input logic [2:0] ec = 3'h0);
    logic [7:0] v;
    logic g;
    logic [2:0] c;
    begin
      host.ack(v, g, c);
      check(g, eg);
      check(v, eg ? ev : 8'h00);
      check(c, ec);
    end
  endtask
  // watchdog: whole run needs well under 5000 cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    close_out();
  end
  // main sequence
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, request_inputs} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    cascade_in = 3'h5;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, bad offsets, bad first word
    rd(`PRI_OFS_FIRST, `PRI_RST_FIRST);
    rd(`PRI_OFS_PRIORITY, {5'h0, `PRI_RST_BOTTOM});
    rd(8'h2C, 8'h00, `PRI_RESP_SLVERR);
    wr(8'h30, 8'hFF, `PRI_RESP_SLVERR);
    wr(`PRI_OFS_MASK, 8'h0F);
    wr(`PRI_OFS_FIRST, 8'h02);
    rd(`PRI_OFS_MASK, 8'h0F);
    wr(`PRI_OFS_FIRST, 8'h13);
    rd(`PRI_OFS_MASK, 8'h00);
    wr(`PRI_OFS_VECTOR, 8'h40);
    req(8'hA4);
    ci(1'b1);
    rd(`PRI_OFS_REQUEST, 8'hA4);
    ackx(8'h42);
    rd(`PRI_OFS_SERVICE, 8'h04);
    ci(1'b0);
    req(8'hA5);
    ci(1'b1);
    ackx(8'h40);
    req(8'hA4);
    cmd(`PRI_CMD_END);
    rd(`PRI_OFS_SERVICE, 8'h04);
    cmd(`PRI_CMD_END);
    rd(`PRI_OFS_SERVICE, 8'h00);
    wr(`PRI_OFS_MASK, 8'hFF);
    ci(1'b0);
    wr(`PRI_OFS_MASK, 8'h04);
    ackx(8'h45);
    ci(1'b0);
    wr(`PRI_OFS_MODE, 8'h01);
    ci(1'b1);
    wr(`PRI_OFS_MODE, 8'h00);
    ci(1'b0);
    wr(`PRI_OFS_MASK, 8'h24);
    ci(1'b0);
    cmd(`PRI_CMD_END);
    ci(1'b1);
    wr(`PRI_OFS_MASK, 8'h00);
    cmd(`PRI_CMD_SET_BOTTOM, 5'h4);
    rd(`PRI_OFS_PRIORITY, 8'h04);
    ackx(8'h45);
    cmd(`PRI_CMD_ROT_SPEC, 5'h5);
    rd(`PRI_OFS_SERVICE, 8'h00);
    rd(`PRI_OFS_PRIORITY, 8'h05);
    ackx(8'h47);
    cmd(`PRI_CMD_ROT_END);
    rd(`PRI_OFS_PRIORITY, 8'h07);
    ackx(8'h42);
    cmd(`PRI_CMD_ROT_END);
    rd(`PRI_OFS_PRIORITY, 8'h02);
    wr(`PRI_OFS_MODE, 8'h02);
    rd(`PRI_OFS_POLL, 8'h85);
    rd(`PRI_OFS_SERVICE, 8'h20);
    rd(`PRI_OFS_POLL, 8'h00);
    cmd(`PRI_CMD_END);
    cmd(`PRI_CMD_SET_BOTTOM, 5'h7);
    wr(`PRI_OFS_FOURTH, 8'h02);
    req(8'h08);
    ackx(8'h43);
    rd(`PRI_OFS_SERVICE, 8'h00);
    // slave in plain nesting answers on identifier
    wr(`PRI_OFS_FIRST, 8'h11);
    wr(`PRI_OFS_VECTOR, 8'h40);
    wr(`PRI_OFS_CASCADE, 8'h05);
    wr(`PRI_OFS_FOURTH, 8'h00);
    ackx(8'h43);
    cmd(`PRI_CMD_END);
    rd(`PRI_OFS_SERVICE, 8'h00);
    cascade_in <= 3'h3;
    ackx(8'h00, 1'b0);
    cmd(`PRI_CMD_END);
    // master sends cascade code, no vector
    wr(`PRI_OFS_CASCADE, 8'h08);
    wr(`PRI_OFS_FOURTH, 8'h14);
    ackx(8'h00, 1'b0, 3'h3);
    ci(1'b1);
    wr(`PRI_OFS_FOURTH, 8'h04);
    ci(1'b0);
    // edge requests, specific end, auto rotate
    wr(`PRI_OFS_FIRST, 8'h1B);
    cmd(`PRI_CMD_END);
    req(8'h00);
    ci(1'b0);
    req(8'h10);
    ci(1'b1);
    ackx(8'h44);
    rd(`PRI_OFS_REQUEST, 8'h00);
    cmd(`PRI_CMD_SPEC_END, 5'h4);
    rd(`PRI_OFS_SERVICE, 8'h00);
    cmd(`PRI_CMD_ROT_AUTO_ON);
    wr(`PRI_OFS_FOURTH, 8'h02);
    req(8'h00);
    req(8'h10);
    ackx(8'h44);
    rd(`PRI_OFS_PRIORITY, 8'h0C);
    close_out();
  end
endmodule // tb_top
